// ### tmr8_timer.sv
// 8-bit timer/counter top: apb registers, compare, flags, pin override
`timescale 1ns/1ns
`include "tmr8_consts.svh"
module tmr8_timer
  import tmr8_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        ext_tick_i,
  input  wire logic        global_irq_en_i,
  input  wire logic        cmp_irq_ack_i,
  input  wire logic        ovf_irq_ack_i,
  output logic             cmp_irq_o,
  output logic             ovf_irq_o,
  input  wire logic        port_out_i,
  input  wire logic        output_pin_direction_i,
  output logic             pin_o,
  output logic             pin_oe_o,
  output logic             compare_output_o
);

  //////////////////////////////////////////////////////////////////////
  // bus decode

  function automatic logic [4:0] reg_sel(input logic [7:0] a);
    reg_sel = 5'h00;
    case (a)
      `TMR8_OFF_CTRL: reg_sel = 5'h01;
      `TMR8_OFF_CNT:  reg_sel = 5'h02;
      `TMR8_OFF_CMP:  reg_sel = 5'h04;
      `TMR8_OFF_FLAG: reg_sel = 5'h08;
      `TMR8_OFF_IEN:  reg_sel = 5'h10;
      default:        reg_sel = 5'h00;
    endcase
  endfunction

  tmr8_unit_if u ();

  logic [7:0]  ctrl_reg;
  logic [7:0]  ocr_act_reg;
  logic [7:0]  ocr_buf_reg;
  logic        ovf_flag_reg;
  logic        cmp_flag_reg;
  logic        ovf_ien_reg;
  logic        cmp_ien_reg;
  logic        blk_reg;
  logic [31:0] prdata_reg;
  logic [4:0]  wsel;
  logic [4:0]  rsel;
  logic        acc;
  logic        wr_en;
  logic        setup;
  logic        pwm;
  logic        eq;
  logic        upd;
  logic        ovf_set;
  logic        cmp_set;
  logic [7:0]  rd_byte;

  assign acc      = psel_i && penable_i;
  assign wr_en    = acc && pwrite_i;
  assign setup    = psel_i && !penable_i;
  assign wsel     = wr_en ? reg_sel(paddr_i) : 5'h00;
  assign rsel     = reg_sel(paddr_i);
  assign pready_o = acc;
  assign pslverr_o = acc && (rsel == 5'h00);
  assign prdata_o = prdata_reg;

  //////////////////////////////////////////////////////////////////////
  // control and core links

  assign pwm = (u.mode == TMR8_FAST) || (u.mode == TMR8_PCPWM);

  assign u.mode      = tmr8_mode_t'(ctrl_reg[`TMR8_WGM_F]);
  assign u.action    = ctrl_reg[`TMR8_COM_F];
  assign u.tick      = (ctrl_reg[`TMR8_CS_F] != 3'h0) && ext_tick_i;
  assign u.ocr       = ocr_act_reg;
  assign u.wr        = wsel[1];
  assign u.wdata     = pwdata_i[7:0];
  assign u.force_cmp = wsel[0] && pwdata_i[`TMR8_FOC_B] && !pwm;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg <= `TMR8_CTRL_RST;
    end else if (wsel[0]) begin
      ctrl_reg <= {1'b0, pwdata_i[6:0]};
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ovf_ien_reg <= 1'b0;
      cmp_ien_reg <= 1'b0;
    end else if (wsel[4]) begin
      ovf_ien_reg <= pwdata_i[`TMR8_OVF_B];
      cmp_ien_reg <= pwdata_i[`TMR8_CMPF_B];
    end
  end

  tmr8_counter counter_u (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .u         (u.ctr)
  );

  tmr8_wave wave_u (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .u         (u.wave),
    .oc_o      (compare_output_o)
  );

  //////////////////////////////////////////////////////////////////////
  // comparator and match blocking

  assign eq    = (u.cnt == ocr_act_reg);
  assign u.hit = u.tick && eq && !blk_reg;

  // a counter write arms the block until the next tick has passed
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      blk_reg <= 1'b0;
    end else if (u.wr) begin
      blk_reg <= 1'b1;
    end else if (u.tick) begin
      blk_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // compare value, buffered in pwm modes

  // fast pwm reloads at bottom, phase correct at top; both follow max
  assign upd = pwm && u.tick && u.at_max;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ocr_buf_reg <= 8'h00;
    end else if (wsel[2]) begin
      ocr_buf_reg <= pwdata_i[7:0];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ocr_act_reg <= 8'h00;
    end else if (wsel[2] && !pwm) begin
      ocr_act_reg <= pwdata_i[7:0];
    end else if (upd) begin
      ocr_act_reg <= ocr_buf_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // flags and interrupt requests

  always_comb begin
    ovf_set = 1'b0;
    if (u.tick && !u.wr) begin
      if (u.mode == TMR8_PCPWM) begin
        ovf_set = u.at_bottom && u.down;
      end else if (u.mode == TMR8_CTC) begin
        ovf_set = u.at_max && !eq;
      end else begin
        ovf_set = u.at_max;
      end
    end
  end

  assign cmp_set = u.hit && !(u.mode == TMR8_CTC && u.wr);

  // set wins over any clear in the same cycle
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ovf_flag_reg <= 1'b0;
    end else if (ovf_set) begin
      ovf_flag_reg <= 1'b1;
    end else if (ovf_irq_ack_i || (wsel[3] && pwdata_i[`TMR8_OVF_B])) begin
      ovf_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_flag_reg <= 1'b0;
    end else if (cmp_set) begin
      cmp_flag_reg <= 1'b1;
    end else if (cmp_irq_ack_i || (wsel[3] && pwdata_i[`TMR8_CMPF_B])) begin
      cmp_flag_reg <= 1'b0;
    end
  end

  assign cmp_irq_o = cmp_flag_reg && cmp_ien_reg && global_irq_en_i;
  assign ovf_irq_o = ovf_flag_reg && ovf_ien_reg && global_irq_en_i;

  //////////////////////////////////////////////////////////////////////
  // port pin override

  assign pin_o    = (u.action != 2'h0) ? compare_output_o : port_out_i;
  assign pin_oe_o = output_pin_direction_i;

  //////////////////////////////////////////////////////////////////////
  // read data, captured in the setup phase

  always_comb begin
    rd_byte = 8'h00;
    case (rsel)
      5'h01: rd_byte = {1'b0, ctrl_reg[6:0]};
      5'h02: rd_byte = u.cnt;
      5'h04: rd_byte = pwm ? ocr_buf_reg : ocr_act_reg;
      5'h08: rd_byte = {6'h00, cmp_flag_reg, ovf_flag_reg};
      5'h10: rd_byte = {6'h00, cmp_ien_reg, ovf_ien_reg};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup && !pwrite_i) begin
      prdata_reg <= {24'h00_0000, rd_byte};
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  stop_hold_a: assert property (
    (ctrl_reg[`TMR8_CS_F] == 3'h0) && !u.wr |=> $stable(u.cnt))
    else $error("counter moved while stopped");

  normal_step_a: assert property (
    u.tick && !u.wr && u.mode == TMR8_NORMAL |=> u.cnt == 8'($past(u.cnt) + 8'h01))
    else $error("normal mode did not count up by one");

  write_prio_a: assert property (
    u.wr |=> u.cnt == $past(u.wdata))
    else $error("counter write lost");

  cmp_flag_a: assert property (
    u.tick && eq && !blk_reg && !u.wr |=> cmp_flag_reg)
    else $error("match did not set compare flag");

  irq_gate_a: assert property (
    cmp_irq_o |-> cmp_flag_reg && cmp_ien_reg && global_irq_en_i)
    else $error("compare irq without its conditions");

  flag_clear_a: assert property (
    cmp_flag_reg && cmp_irq_ack_i && !cmp_set |=> !cmp_flag_reg)
    else $error("compare flag not cleared by service");

  block_match_a: assert property (
    u.wr ##1 (!u.wr && u.tick) |-> !u.hit)
    else $error("match after counter write not blocked");

  ovf_set_a: assert property (
    u.tick && !u.wr && u.mode == TMR8_NORMAL && u.at_max |=> ovf_flag_reg && u.at_bottom)
    else $error("overflow flag not set at wrap");

  buffer_hold_a: assert property (
    pwm && !upd && $stable(u.mode) |=> $stable(ocr_act_reg))
    else $error("active compare changed outside reload");

  ctc_clear_a: assert property (
    u.tick && !u.wr && u.mode == TMR8_CTC && eq |=> u.at_bottom)
    else $error("clear-on-match did not clear");

  pin_sel_a: assert property (
    (u.action != 2'h0) |-> pin_o == compare_output_o)
    else $error("pin not overridden");

  hold_state_a: assert property (
    u.action == 2'h0 |=> $stable(compare_output_o))
    else $error("output changed with action zero");

  pc_turn_a: assert property (
    u.tick && !u.wr && u.mode == TMR8_PCPWM && u.at_max ##1 u.mode == TMR8_PCPWM
    |-> u.cnt == 8'hFE)
    else $error("phase correct did not turn at max");

  ovf_wrap_c: cover property (u.tick && u.mode == TMR8_NORMAL && u.at_max);
  ctc_match_c: cover property (u.hit && u.mode == TMR8_CTC);
  pc_down_c: cover property (u.tick && u.mode == TMR8_PCPWM && u.down && u.hit);
  force_c: cover property (u.force_cmp && u.action == 2'h1);

endmodule

// ### tmr8_consts.svh
// constants of the 8-bit timer/counter with one compare channel
// Overview of operation
// - clock select zero stops the counter
// - each tick clears, increments or decrements once
// - cpu access anytime; cpu write beats counting
// - 8-bit equality sets compare flag next tick
// - compare irq needs flag, enable, global enable
// - flag clears on service or written one
// - pwm modes double buffer compare value
// - cpu reaches buffer or active copy
// - force strobe acts like match, no flag; ignored in pwm modes
// - counter write blocks match next tick
// - output state resets to zero
// - output state kept across mode change
// - output action unbuffered, effective next match
// - nonzero action overrides port output value
// - action zero leaves output state unchanged
// - counting depends only on waveform mode
// - normal mode counts up, wraps FF to 00
// - overflow flag set as counter wraps to zero; in phase correct as it turns up at zero
// - overflow service clears overflow flag
// - counter gives top and bottom indications
// - clear-on-match clears at compare value
// - fast pwm counts bottom to max, restarts
// - phase correct counts up then down
`ifndef TMR8_CONSTS_SVH
`define TMR8_CONSTS_SVH
`define TMR8_OFF_CTRL 8'h00
`define TMR8_OFF_CNT  8'h04
`define TMR8_OFF_CMP  8'h08
`define TMR8_OFF_FLAG 8'h0C
`define TMR8_OFF_IEN  8'h10
`define TMR8_CS_F     2:0
`define TMR8_WGM_F    4:3
`define TMR8_COM_F    6:5
`define TMR8_FOC_B    7
`define TMR8_OVF_B    0
`define TMR8_CMPF_B   1
`define TMR8_CTRL_RST 8'h00
`define TMR8_CNT_RST  8'h00
`define TMR8_MAX      8'hFF
`define TMR8_BOTTOM   8'h00
`endif

// ### tmr8_pkg.sv
// types of the 8-bit timer/counter
package tmr8_pkg;
  typedef enum logic [1:0] {
    TMR8_NORMAL = 2'h0,
    TMR8_PCPWM  = 2'h1,
    TMR8_CTC    = 2'h2,
    TMR8_FAST   = 2'h3
  } tmr8_mode_t;
endpackage

// ### tmr8_unit_if.sv
// signals shared by the timer core, its counter and its output unit
`timescale 1ns/1ns
interface tmr8_unit_if;
  import tmr8_pkg::*;
  logic       tick;
  tmr8_mode_t mode;
  logic [7:0] ocr;
  logic       wr;
  logic [7:0] wdata;
  logic [7:0] cnt;
  logic       down;
  logic       at_max;
  logic       at_bottom;
  logic       hit;
  logic       force_cmp;
  logic [1:0] action;
  modport core (output tick, mode, ocr, wr, wdata, hit, force_cmp, action,
                input cnt, down, at_max, at_bottom);
  modport ctr (input tick, mode, ocr, wr, wdata,
               output cnt, down, at_max, at_bottom);
  modport wave (input tick, mode, hit, force_cmp, action, down, at_max);
endinterface

// ### tmr8_counter.sv
// bidirectional 8-bit counter unit
`timescale 1ns/1ns
`include "tmr8_consts.svh"
module tmr8_counter
  import tmr8_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  tmr8_unit_if.ctr  u
);
  logic [7:0] cnt_reg;
  logic       down_reg;
  logic       down_next;

  assign u.cnt       = cnt_reg;
  assign u.down      = down_reg;
  assign u.at_max    = (cnt_reg == `TMR8_MAX);
  assign u.at_bottom = (cnt_reg == `TMR8_BOTTOM);

  // dual slope turns at max and at bottom
  always_comb begin
    down_next = down_reg;
    if (u.at_max) begin
      down_next = 1'b1;
    end else if (u.at_bottom) begin
      down_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= `TMR8_CNT_RST;
    end else if (u.wr) begin
      cnt_reg <= u.wdata;
    end else if (u.tick) begin
      case (u.mode)
        TMR8_CTC: cnt_reg <= (cnt_reg == u.ocr) ? `TMR8_BOTTOM : cnt_reg + 8'h01;
        TMR8_PCPWM: cnt_reg <= down_next ? cnt_reg - 8'h01 : cnt_reg + 8'h01;
        default: cnt_reg <= cnt_reg + 8'h01;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      down_reg <= 1'b0;
    end else if (u.mode != TMR8_PCPWM) begin
      down_reg <= 1'b0;
    end else if (u.tick && !u.wr) begin
      down_reg <= down_next;
    end
  end
endmodule

// ### tmr8_wave.sv
// waveform generator holding the compare output state
`timescale 1ns/1ns
`include "tmr8_consts.svh"
module tmr8_wave
  import tmr8_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  tmr8_unit_if.wave u,
  output logic      oc_o
);
  logic oc_reg;
  logic oc_next;
  logic pol;

  assign oc_o = oc_reg;
  assign pol  = u.action[0];

  always_comb begin
    oc_next = oc_reg;
    case (u.mode)
      TMR8_NORMAL, TMR8_CTC: begin
        if (u.hit || u.force_cmp) begin
          case (u.action)
            2'h1: oc_next = ~oc_reg;
            2'h2: oc_next = 1'b0;
            2'h3: oc_next = 1'b1;
            default: oc_next = oc_reg;
          endcase
        end
      end
      TMR8_FAST: begin
        if (u.action[1] && u.tick && u.at_max) begin
          oc_next = ~pol;
        end else if (u.action[1] && u.hit) begin
          oc_next = pol;
        end else if (u.action == 2'h1 && u.hit) begin
          oc_next = ~oc_reg;
        end
      end
      TMR8_PCPWM: begin
        if (u.action[1] && u.hit) begin
          oc_next = u.down ? ~pol : pol;
        end
      end
      default: oc_next = oc_reg;
    endcase
  end

  // mode changes never touch the state
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      oc_reg <= 1'b0;
    end else begin
      oc_reg <= oc_next;
    end
  end
endmodule

// ### tb_tmr8_timer.sv
// self-checking bench of the 8-bit timer/counter
`timescale 1ns/1ns
`include "tmr8_consts.svh"
module tb_tmr8_timer;
  import tmr8_pkg::*;
  logic        ref_clk_i, rst_i, psel_i, penable_i, pwrite_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic        pready_o, pslverr_o, ext_tick_i, global_irq_en_i;
  logic        cmp_irq_ack_i, ovf_irq_ack_i, cmp_irq_o, ovf_irq_o;
  logic        port_out_i, output_pin_direction_i, pin_o, pin_oe_o;
  logic        compare_output_o, er;
  int          n_errors, checks_done;

  tmr8_timer tmr8_timer_inst (.ref_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .ext_tick_i,
    .global_irq_en_i, .cmp_irq_ack_i, .ovf_irq_ack_i, .cmp_irq_o, .ovf_irq_o,
    .port_out_i, .output_pin_direction_i, .pin_o, .pin_oe_o, .compare_output_o);

  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  // one apb transfer; holds the request until pready is seen high or 20 cycles pass
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    i = 0;
    do begin
      @(posedge ref_clk_i);
      i++;
    end while (pready_o !== 1'b1 && i < 20);
    if (i >= 20) chk("pready", 32'h1, 32'h0);
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(what, {24'h000000, e}, rd);
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      ext_tick_i <= 1'b1;
      @(posedge ref_clk_i);
      ext_tick_i <= 1'b0;
    end
  endtask

  // action bits land one write ahead of the force strobe that uses them
  task automatic ocheck(input logic [7:0] d, input logic e);
    wr(`TMR8_OFF_CTRL, d & 8'h7F);
    wr(`TMR8_OFF_CTRL, d);
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("compare output", {31'h0, e}, {31'h0, compare_output_o});
  endtask

////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk("output state", 32'h0, {31'h0, compare_output_o});
    rchk("control", `TMR8_OFF_CTRL, 8'h00);
    rchk("count", `TMR8_OFF_CNT, 8'h00);
    apb(1'b0, 8'h14, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    $display("reset test done");
  endtask

  task automatic t_stop;
    wr(`TMR8_OFF_CNT, 8'h5A);
    ext_tick_i <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    rchk("stopped count", `TMR8_OFF_CNT, 8'h5A);
    ext_tick_i <= 1'b0;
    $display("stop test done");
  endtask

  task automatic t_wrap;
    wr(`TMR8_OFF_CMP, 8'h80);
    wr(`TMR8_OFF_IEN, 8'h01);
    wr(`TMR8_OFF_CNT, 8'hFE);
    wr(`TMR8_OFF_CTRL, 8'h01);
    tick(1);
    rchk("count up", `TMR8_OFF_CNT, 8'hFF);
    chk("ovf irq low", 32'h0, {31'h0, ovf_irq_o});
    tick(1);
    rchk("wrapped count", `TMR8_OFF_CNT, 8'h00);
    rchk("ovf flag", `TMR8_OFF_FLAG, 8'h01);
    chk("ovf irq", 32'h1, {31'h0, ovf_irq_o});
    @(posedge ref_clk_i);
    ovf_irq_ack_i <= 1'b1;
    @(posedge ref_clk_i);
    ovf_irq_ack_i <= 1'b0;
    rchk("ovf cleared", `TMR8_OFF_FLAG, 8'h00);
    $display("wrap test done");
  endtask

  task automatic t_match;
    wr(`TMR8_OFF_CTRL, 8'h00);
    wr(`TMR8_OFF_CMP, 8'h10);
    wr(`TMR8_OFF_CTRL, 8'h01);
    wr(`TMR8_OFF_CNT, 8'h10);
    ext_tick_i <= 1'b1;
    @(posedge ref_clk_i);
    ext_tick_i <= 1'b0;
    rchk("blocked match", `TMR8_OFF_FLAG, 8'h00);
    wr(`TMR8_OFF_CNT, 8'h0F);
    tick(2);
    rchk("cmp flag", `TMR8_OFF_FLAG, 8'h02);
    wr(`TMR8_OFF_IEN, 8'h02);
    @(posedge ref_clk_i);
    global_irq_en_i <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    chk("cmp irq masked", 32'h0, {31'h0, cmp_irq_o});
    @(posedge ref_clk_i);
    global_irq_en_i <= 1'b1;
    @(posedge ref_clk_i);
    #1;
    chk("cmp irq", 32'h1, {31'h0, cmp_irq_o});
    wr(`TMR8_OFF_FLAG, 8'h02);
    rchk("cmp write clear", `TMR8_OFF_FLAG, 8'h00);
    wr(`TMR8_OFF_CNT, 8'h0F);
    tick(2);
    rchk("cmp flag again", `TMR8_OFF_FLAG, 8'h02);
    @(posedge ref_clk_i);
    cmp_irq_ack_i <= 1'b1;
    @(posedge ref_clk_i);
    cmp_irq_ack_i <= 1'b0;
    rchk("cmp ack clear", `TMR8_OFF_FLAG, 8'h00);
    $display("match test done");
  endtask

  task automatic t_force;
    port_out_i <= 1'b0;
    ocheck(8'hE0, 1'b1);
    chk("pin enable off", 32'h0, {31'h0, pin_oe_o});
    @(posedge ref_clk_i);
    output_pin_direction_i <= 1'b1;
    @(posedge ref_clk_i);
    #1;
    chk("pin override", 32'h1, {31'h0, pin_o});
    chk("pin enable", 32'h1, {31'h0, pin_oe_o});
    ocheck(8'hC0, 1'b0);
    ocheck(8'hA0, 1'b1);
    ocheck(8'h80, 1'b1);
    chk("pin port value", 32'h0, {31'h0, pin_o});
    rchk("no flag on force", `TMR8_OFF_FLAG, 8'h00);
    ocheck(8'h10, 1'b1);
    $display("force test done");
  endtask

  task automatic t_ctc;
    wr(`TMR8_OFF_CMP, 8'h03);
    wr(`TMR8_OFF_CNT, 8'h00);
    ocheck(8'h31, 1'b1);
    tick(4);
    rchk("ctc count", `TMR8_OFF_CNT, 8'h00);
    rchk("ctc flag", `TMR8_OFF_FLAG, 8'h02);
    chk("toggled output", 32'h0, {31'h0, compare_output_o});
    wr(`TMR8_OFF_FLAG, 8'h03);
    $display("ctc test done");
  endtask

  task automatic t_pwm;
    wr(`TMR8_OFF_CTRL, 8'h08);
    wr(`TMR8_OFF_CMP, 8'h40);
    rchk("buffer read", `TMR8_OFF_CMP, 8'h40);
    wr(`TMR8_OFF_CNT, 8'hFD);
    wr(`TMR8_OFF_CTRL, 8'h09);
    tick(3);
    rchk("dual slope", `TMR8_OFF_CNT, 8'hFE);
    wr(`TMR8_OFF_CTRL, 8'h18);
    wr(`TMR8_OFF_CNT, 8'hFE);
    wr(`TMR8_OFF_CTRL, 8'h19);
    tick(2);
    rchk("fast restart", `TMR8_OFF_CNT, 8'h00);
    $display("pwm test done");
  endtask

////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_errors++;
    close_out;
  end

  initial begin
    rst_i = 1'b1;
    {psel_i, penable_i, pwrite_i, ext_tick_i, cmp_irq_ack_i, ovf_irq_ack_i} = 6'h00;
    {global_irq_en_i, port_out_i, output_pin_direction_i} = 3'h4;
    paddr_i  = 8'h00;
    pwdata_i = 32'h00000000;
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_stop;
    t_wrap;
    t_match;
    t_force;
    t_ctc;
    t_pwm;
    close_out;
  end
endmodule
